// ---- audio_route_defs.vh ----
`ifndef AUDIO_ROUTE_DEFS_VH
`define AUDIO_ROUTE_DEFS_VH

// Register port word addresses
`define ROUTE_CMD_ADDR 8'h10
`define SHIFT_CMD_ADDR 8'h11
`define MIC_GAIN_ADDR 8'h12
`define READBACK_BASE 8'h20
`define READBACK_LAST 8'h31
`define FILT_SEL_ADDR 8'h40
`define FILT_BYPASS_ADDR 8'h41
`define FILT_COEF_BASE 8'h50
`define FILT_COEF_LAST 8'h59
`define PHASE_ADDR 8'h60

// Command argument fields
`define ARG_DEST_HI 15
`define ARG_DEST_LO 8
`define ARG_VAL_HI 7
`define ARG_VAL_LO 0
`define ARG_SAT_BIT 8

// Destination counts
`define DST_COUNT 8'h06
`define DST_OUT_COUNT 8'h04

// Source indexes
`define SRC_ZERO 5'h00
`define SRC_USB_MEAN 5'h01
`define SRC_USB_HALF_DIFF 5'h02
`define SRC_SER_MEAN 5'h03
`define SRC_SER_HALF_DIFF 5'h04
`define SRC_PIPE_0 5'h05
`define SRC_PIPE_1 5'h06
`define SRC_USB_LEFT 5'h07
`define SRC_USB_RIGHT 5'h08
`define SRC_SER_LEFT 5'h09
`define SRC_SER_RIGHT 5'h0a
`define SRC_MIC_0 5'h0b
`define SRC_MIC_1 5'h0c
`define SRC_PACKED_PIPE 5'h0d
`define SRC_PACKED_MIC 5'h0e
`define SRC_PACKED_REF 5'h0f
`define SRC_PACKED_ALL 5'h10

// Boot routing and shift
`define BOOT_SRC_0 5'h05
`define BOOT_SRC_1 5'h06
`define BOOT_SRC_2 5'h05
`define BOOT_SRC_3 5'h09
`define BOOT_SRC_4 5'h07
`define BOOT_SRC_5 5'h08
`define BOOT_SHIFT 8'h00
`define BOOT_MIC_SHIFT 7'h00
`define BOOT_BYPASS 4'hf

// Filter layout and 48k-to-16k framing
`define COEF_COUNT 4'ha
`define COEF_PER_SECTION 4'h5
`define COEF_FRAC 28
`define PHASE_LAST 2'h2

`endif

// ---- audio_shift_sat.v ----
`timescale 1ns/1ps
// Power-of-two gain: left for positive shift, arithmetic right for negative
module audio_shift_sat #(
    parameter W = 24,
    parameter SW = 8
) (
    // Sample and settings
    input wire [W-1:0] sample_in,
    input wire [SW-1:0] shift_in,
    input wire sat_en_in,
    // Scaled sample
    output reg [W-1:0] sample_out
);
    localparam [SW-1:0] AMT_CAP = W[SW-1:0];

    reg [SW-1:0] mag;
    reg [SW-1:0] amt;
    reg [2*W-1:0] wide;
    reg [2*W-1:0] moved;
    reg fits;

    // Magnitude capped at W; anything larger behaves the same
    always @*
    begin
        mag = shift_in[SW-1] ? (~shift_in + {{(SW-1){1'b0}}, 1'b1}) : shift_in;
        amt = (mag > AMT_CAP) ? AMT_CAP : mag;
        wide = {{W{sample_in[W-1]}}, sample_in};
        moved = wide <<< amt;
        fits = (&moved[2*W-1:W-1]) | (~|moved[2*W-1:W-1]);
        if (shift_in[SW-1])
            sample_out = $signed(sample_in) >>> amt;
        else if (!fits && sat_en_in)
            sample_out = sample_in[W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
        else
            sample_out = moved[W-1:0];
    end
endmodule // audio_shift_sat

// ---- biquad_pair.v ----
`timescale 1ns/1ps
`include "audio_route_defs.vh"
// Two cascaded biquads; feedback coefficients are stored pre-negated
module biquad_pair #(
    parameter W = 24,
    parameter CW = 32
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Samples
    input wire sample_en_in,
    input wire bypass_in,
    input wire [W-1:0] x_in,
    output reg [W-1:0] y_out,
    // Coefficient access, order a1 a2 b0 b1 b2 per section
    input wire coef_wr_in,
    input wire [3:0] coef_idx_in,
    input wire [CW-1:0] coef_data_in,
    input wire [3:0] coef_rd_idx_in,
    output wire [CW-1:0] coef_rd_out
);
    localparam AW = CW + W + 4;

    reg [CW-1:0] coef [0:9];
    reg [W-1:0] x1a, x2a, y1a, y2a, x1b, x2b, y1b, y2b;
    wire [W-1:0] mid;
    wire [W-1:0] fin;
    integer i;

    // One section with saturation back to W bits
    function [W-1:0] section;
        input [CW-1:0] ca1, ca2, cb0, cb1, cb2;
        input [W-1:0] x, x1, x2, y1, y2;
        reg signed [AW-1:0] acc;
        begin
            acc = $signed(cb0) * $signed(x) + $signed(cb1) * $signed(x1) + $signed(cb2) * $signed(x2)
                + $signed(ca1) * $signed(y1) + $signed(ca2) * $signed(y2);
            acc = acc >>> `COEF_FRAC;
            if ((&acc[AW-1:W-1]) | (~|acc[AW-1:W-1]))
                section = acc[W-1:0];
            else
                section = acc[AW-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
        end
    endfunction

    assign mid = section(coef[0], coef[1], coef[2], coef[3], coef[4], x_in, x1a, x2a, y1a, y2a);
    assign fin = section(coef[5], coef[6], coef[7], coef[8], coef[9], mid, x1b, x2b, y1b, y2b);
    assign coef_rd_out = (coef_rd_idx_in < `COEF_COUNT) ? coef[coef_rd_idx_in] : {CW{1'b0}};

    // Coefficients cleared at reset, each word writable on its own
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            for (i = 0; i < 10; i = i + 1)
                coef[i] <= {CW{1'b0}};
        end
        else if (coef_wr_in && coef_idx_in < `COEF_COUNT)
        begin
            coef[coef_idx_in] <= coef_data_in;
        end
    end

    // Delay lines run even when bypassed, so enabling is glitch-light
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            {x1a, x2a, y1a, y2a, x1b, x2b, y1b, y2b} <= {(8*W){1'b0}};
            y_out <= {W{1'b0}};
        end
        else if (sample_en_in)
        begin
            x1a <= x_in;
            x2a <= x1a;
            y1a <= mid;
            y2a <= y1a;
            x1b <= mid;
            x2b <= x1b;
            y1b <= fin;
            y2b <= y1b;
            y_out <= bypass_in ? x_in : fin;
        end
    end
endmodule // biquad_pair

// ---- audio_route_gain_matrix.v ----
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "audio_route_defs.vh"
module audio_route_gain_matrix #(
    parameter W = 24,
    parameter CW = 32
) (
    // Clock and reset
    input wire CLK_IN,
    input wire RST_IN,
    // Register port
    input wire [7:0] ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [31:0] RDATA_OUT,
    // 48 kHz sample tick and audio sources
    input wire SAMPLE_EN_IN,
    input wire [W-1:0] USB_RX_LEFT_IN,
    input wire [W-1:0] USB_RX_RIGHT_IN,
    input wire [W-1:0] SERIAL_AUDIO_RX_LEFT_IN,
    input wire [W-1:0] SERIAL_AUDIO_RX_RIGHT_IN,
    input wire [W-1:0] PIPE_OUT_LEFT_IN,
    input wire [W-1:0] PIPE_OUT_RIGHT_IN,
    input wire [W-1:0] MIC_RAW_LEFT_IN,
    input wire [W-1:0] MIC_RAW_RIGHT_IN,
    // 48 kHz destinations
    output reg [W-1:0] USB_TX_LEFT_OUT,
    output reg [W-1:0] USB_TX_RIGHT_OUT,
    output reg [W-1:0] SERIAL_AUDIO_TX_LEFT_OUT,
    output reg [W-1:0] SERIAL_AUDIO_TX_RIGHT_OUT,
    output reg [W-1:0] ECHO_REFERENCE_LEFT_OUT,
    output reg [W-1:0] ECHO_REFERENCE_RIGHT_OUT,
    output reg OUT_VALID_OUT,
    // 16 kHz microphone feed into the pipeline
    output reg [W-1:0] MIC_TO_PIPE_LEFT_OUT,
    output reg [W-1:0] MIC_TO_PIPE_RIGHT_OUT,
    output reg MIC_VALID_OUT
);
    // Settings
    reg [4:0] route [0:5];
    reg [7:0] gain_shift [0:5];
    reg [6:0] mic_shift;
    reg mic_sat;
    reg [1:0] filt_sel;
    reg [3:0] bypass;

    // Sample path state
    reg [1:0] phase;
    reg en_d1, en_d2;
    reg [W-1:0] stage [0:5];
    reg [W-1:0] mic_held0, mic_held1;
    reg [W-1:0] pipe_held0, pipe_held1;
    reg [W-1:0] ref_held0, ref_held1;

    // Combinational
    reg [W-1:0] picked [0:5];
    wire [W-1:0] scaled [0:5];
    wire [W-1:0] filt_y [0:3];
    wire [CW-1:0] coef_rd [0:3];
    wire [W-1:0] mic_gain0, mic_gain1;
    wire [W-1:0] usb_rx_mean, usb_rx_half_diff;
    wire [W-1:0] serial_audio_rx_mean, serial_audio_rx_half_diff;
    reg [31:0] next_rdata;
    reg [7:0] rb_idx;
    reg [3:0] coef_off;
    wire [7:0] arg_dest;
    wire [4:0] arg_src;
    wire src_ok;
    // One loop index per process; a shared one would make the decoders retrigger each other
    integer d, k, m, q;

    // Sum or difference widened by one bit, then halved
    function [W-1:0] halve;
        input [W-1:0] a;
        input [W-1:0] b;
        input sub;
        reg [W:0] t;
        begin
            t = sub ? ({a[W-1], a} - {b[W-1], b}) : ({a[W-1], a} + {b[W-1], b});
            halve = t[W:1];
        end
    endfunction

    // Pick one of three 16 kHz words for the current 48 kHz slot
    function [W-1:0] slot3;
        input [W-1:0] s0;
        input [W-1:0] s1;
        input [W-1:0] s2;
        input [1:0] ph;
        begin
            case (ph)
                2'h0: slot3 = s0;
                2'h1: slot3 = s1;
                default: slot3 = s2;
            endcase
        end
    endfunction

    assign usb_rx_mean = halve(USB_RX_LEFT_IN, USB_RX_RIGHT_IN, 1'b0);
    assign usb_rx_half_diff = halve(USB_RX_LEFT_IN, USB_RX_RIGHT_IN, 1'b1);
    assign serial_audio_rx_mean = halve(SERIAL_AUDIO_RX_LEFT_IN, SERIAL_AUDIO_RX_RIGHT_IN, 1'b0);
    assign serial_audio_rx_half_diff = halve(SERIAL_AUDIO_RX_LEFT_IN, SERIAL_AUDIO_RX_RIGHT_IN, 1'b1);

    assign arg_dest = WDATA_IN[`ARG_DEST_HI:`ARG_DEST_LO];
    assign arg_src = WDATA_IN[4:0];
    assign src_ok = (WDATA_IN[`ARG_VAL_HI:5] == 3'h0) && (arg_src <= `SRC_PACKED_ALL);

    // Raw microphone gain ahead of the pipeline
    audio_shift_sat #(.W(W), .SW(8)) u_mic_gain0 (
        .sample_in(MIC_RAW_LEFT_IN),
        .shift_in({1'b0, mic_shift}),
        .sat_en_in(mic_sat),
        .sample_out(mic_gain0)
    );
    audio_shift_sat #(.W(W), .SW(8)) u_mic_gain1 (
        .sample_in(MIC_RAW_RIGHT_IN),
        .shift_in({1'b0, mic_shift}),
        .sat_en_in(mic_sat),
        .sample_out(mic_gain1)
    );

    // Source selectors; odd destinations are the right channel of their pair
    always @*
    begin
        for (d = 0; d < 6; d = d + 1)
        begin
            case (route[d])
                `SRC_ZERO: picked[d] = {W{1'b0}};
                `SRC_USB_MEAN: picked[d] = usb_rx_mean;
                `SRC_USB_HALF_DIFF: picked[d] = usb_rx_half_diff;
                `SRC_SER_MEAN: picked[d] = serial_audio_rx_mean;
                `SRC_SER_HALF_DIFF: picked[d] = serial_audio_rx_half_diff;
                `SRC_PIPE_0: picked[d] = PIPE_OUT_LEFT_IN;
                `SRC_PIPE_1: picked[d] = PIPE_OUT_RIGHT_IN;
                `SRC_USB_LEFT: picked[d] = USB_RX_LEFT_IN;
                `SRC_USB_RIGHT: picked[d] = USB_RX_RIGHT_IN;
                `SRC_SER_LEFT: picked[d] = SERIAL_AUDIO_RX_LEFT_IN;
                `SRC_SER_RIGHT: picked[d] = SERIAL_AUDIO_RX_RIGHT_IN;
                `SRC_MIC_0: picked[d] = mic_held0;
                `SRC_MIC_1: picked[d] = mic_held1;
                `SRC_PACKED_PIPE: picked[d] = slot3(pipe_held0, pipe_held1, {W{1'b0}}, phase);
                `SRC_PACKED_MIC: picked[d] = slot3(mic_held0, mic_held1, {W{1'b0}}, phase);
                `SRC_PACKED_REF: picked[d] = slot3(ref_held0, ref_held1, {W{1'b0}}, phase);
                `SRC_PACKED_ALL:
                begin
                    if (d % 2 == 0)
                        picked[d] = slot3(mic_held0, ref_held0, pipe_held0, phase);
                    else
                        picked[d] = slot3(mic_held1, ref_held1, pipe_held1, phase);
                end
                default: picked[d] = {W{1'b0}};
            endcase
        end
    end

    // Per-destination gain, output filters on the four outgoing channels
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : dest
            audio_shift_sat #(.W(W), .SW(8)) u_gain (
                .sample_in(picked[g]),
                .shift_in(gain_shift[g]),
                .sat_en_in(1'b1),
                .sample_out(scaled[g])
            );
        end
        for (g = 0; g < 4; g = g + 1)
        begin : filt
            biquad_pair #(.W(W), .CW(CW)) u_filter (
                .clk_in(CLK_IN),
                .rst_in(RST_IN),
                .sample_en_in(en_d1),
                .bypass_in(bypass[g]),
                .x_in(stage[g]),
                .y_out(filt_y[g]),
                .coef_wr_in(WR_IN && filt_sel == g && ADDR_IN >= `FILT_COEF_BASE && ADDR_IN <= `FILT_COEF_LAST),
                .coef_idx_in(coef_off),
                .coef_data_in(WDATA_IN[CW-1:0]),
                .coef_rd_idx_in(coef_off),
                .coef_rd_out(coef_rd[g])
            );
        end
    endgenerate

    // Settings writes; bad destination or source leaves everything unchanged
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            route[0] <= `BOOT_SRC_0;
            route[1] <= `BOOT_SRC_1;
            route[2] <= `BOOT_SRC_2;
            route[3] <= `BOOT_SRC_3;
            route[4] <= `BOOT_SRC_4;
            route[5] <= `BOOT_SRC_5;
            for (k = 0; k < 6; k = k + 1)
                gain_shift[k] <= `BOOT_SHIFT;
            mic_shift <= `BOOT_MIC_SHIFT;
            mic_sat <= 1'b0;
            filt_sel <= 2'h0;
            bypass <= `BOOT_BYPASS;
        end
        else if (WR_IN)
        begin
            case (ADDR_IN)
                `ROUTE_CMD_ADDR:
                begin
                    if (arg_dest < `DST_COUNT && src_ok)
                    begin
                        route[arg_dest[2:0]] <= arg_src;
                        if (arg_src == `SRC_PACKED_ALL && arg_dest < `DST_OUT_COUNT)
                            route[arg_dest[2:0] ^ 3'h1] <= arg_src;
                    end
                end
                `SHIFT_CMD_ADDR:
                begin
                    if (arg_dest < `DST_COUNT)
                        gain_shift[arg_dest[2:0]] <= WDATA_IN[`ARG_VAL_HI:`ARG_VAL_LO];
                end
                `MIC_GAIN_ADDR:
                begin
                    mic_shift <= WDATA_IN[6:0];
                    mic_sat <= WDATA_IN[`ARG_SAT_BIT];
                end
                `FILT_SEL_ADDR: filt_sel <= WDATA_IN[1:0];
                `FILT_BYPASS_ADDR: bypass[filt_sel] <= WDATA_IN[0];
                default: filt_sel <= filt_sel;
            endcase
        end
    end

    // Read decode; unmapped addresses read zero
    always @*
    begin
        next_rdata = 32'h0;
        rb_idx = ADDR_IN - `READBACK_BASE;
        coef_off = ADDR_IN[3:0];
        if (ADDR_IN >= `READBACK_BASE && ADDR_IN <= `READBACK_LAST)
        begin
            for (m = 0; m < 6; m = m + 1)
            begin
                if (rb_idx == 3 * m)
                    next_rdata = m;
                else if (rb_idx == 3 * m + 1)
                    next_rdata = {27'h0, route[m]};
                else if (rb_idx == 3 * m + 2)
                    next_rdata = {{24{gain_shift[m][7]}}, gain_shift[m]};
            end
        end
        else if (ADDR_IN >= `FILT_COEF_BASE && ADDR_IN <= `FILT_COEF_LAST)
            next_rdata = coef_rd[filt_sel];
        else
        begin
            case (ADDR_IN)
                `MIC_GAIN_ADDR: next_rdata = {23'h0, mic_sat, 1'b0, mic_shift};
                `FILT_SEL_ADDR: next_rdata = {30'h0, filt_sel};
                `FILT_BYPASS_ADDR: next_rdata = {31'h0, bypass[filt_sel]};
                `PHASE_ADDR: next_rdata = {30'h0, phase};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
            RDATA_OUT <= 32'h0;
        else
            RDATA_OUT <= RD_IN ? next_rdata : 32'h0;
    end

    // Sample pipeline: select and scale, filter, then present
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            phase <= 2'h0;
            en_d1 <= 1'b0;
            en_d2 <= 1'b0;
            for (q = 0; q < 6; q = q + 1)
                stage[q] <= {W{1'b0}};
            {mic_held0, mic_held1, pipe_held0, pipe_held1, ref_held0, ref_held1} <= {(6*W){1'b0}};
            MIC_TO_PIPE_LEFT_OUT <= {W{1'b0}};
            MIC_TO_PIPE_RIGHT_OUT <= {W{1'b0}};
            MIC_VALID_OUT <= 1'b0;
        end
        else
        begin
            en_d1 <= SAMPLE_EN_IN;
            en_d2 <= en_d1;
            MIC_VALID_OUT <= SAMPLE_EN_IN && phase == 2'h0;
            if (SAMPLE_EN_IN)
            begin
                phase <= (phase == `PHASE_LAST) ? 2'h0 : phase + 2'h1;
                for (q = 0; q < 6; q = q + 1)
                    stage[q] <= scaled[q];
                // One 16 kHz word held across three 48 kHz slots, no interpolation
                if (phase == 2'h0)
                begin
                    mic_held0 <= mic_gain0;
                    mic_held1 <= mic_gain1;
                    pipe_held0 <= PIPE_OUT_LEFT_IN;
                    pipe_held1 <= PIPE_OUT_RIGHT_IN;
                    ref_held0 <= stage[4];
                    ref_held1 <= stage[5];
                    MIC_TO_PIPE_LEFT_OUT <= mic_gain0;
                    MIC_TO_PIPE_RIGHT_OUT <= mic_gain1;
                end
            end
        end
    end

    // Outputs update together three cycles after the tick
    always @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            USB_TX_LEFT_OUT <= {W{1'b0}};
            USB_TX_RIGHT_OUT <= {W{1'b0}};
            SERIAL_AUDIO_TX_LEFT_OUT <= {W{1'b0}};
            SERIAL_AUDIO_TX_RIGHT_OUT <= {W{1'b0}};
            ECHO_REFERENCE_LEFT_OUT <= {W{1'b0}};
            ECHO_REFERENCE_RIGHT_OUT <= {W{1'b0}};
            OUT_VALID_OUT <= 1'b0;
        end
        else
        begin
            OUT_VALID_OUT <= en_d2;
            if (en_d2)
            begin
                USB_TX_LEFT_OUT <= filt_y[0];
                USB_TX_RIGHT_OUT <= filt_y[1];
                SERIAL_AUDIO_TX_LEFT_OUT <= filt_y[2];
                SERIAL_AUDIO_TX_RIGHT_OUT <= filt_y[3];
                ECHO_REFERENCE_LEFT_OUT <= stage[4];
                ECHO_REFERENCE_RIGHT_OUT <= stage[5];
            end
        end
    end
endmodule // audio_route_gain_matrix

// ---- route_matrix_props.sv ----
`timescale 1ns/1ps
module route_matrix_props #(
    parameter W = 24
) (
    // Clock, reset, register port
    input wire CLK_IN,
    input wire RST_IN,
    input wire [7:0] ADDR_IN,
    input wire RD_IN,
    input wire [31:0] RDATA_OUT,
    // Stream side
    input wire SAMPLE_EN_IN,
    input wire OUT_VALID_OUT,
    input wire [W-1:0] USB_TX_LEFT_OUT,
    input wire MIC_VALID_OUT,
    input wire [W-1:0] MIC_TO_PIPE_LEFT_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // Register port answers
    property p_rd_idle; !RD_IN |=> RDATA_OUT == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_rb_dest;
        RD_IN && ADDR_IN >= 8'h20 && ADDR_IN <= 8'h31 && (ADDR_IN - 8'h20) % 3 == 0
        |=> RDATA_OUT == {24'h0, ($past(ADDR_IN) - 8'h20) / 8'h03};
    endproperty
    a_rb_dest: assert property (p_rb_dest) else $error("bad destination word");
    // Output timing: three edges after the tick, one cycle wide
    property p_out_lat; SAMPLE_EN_IN |-> ##3 OUT_VALID_OUT; endproperty
    a_out_lat: assert property (p_out_lat) else $error("late output");
    property p_out_cause; OUT_VALID_OUT |-> $past(SAMPLE_EN_IN, 3); endproperty
    a_out_cause: assert property (p_out_cause) else $error("output without tick");
    property p_out_pulse; OUT_VALID_OUT |=> !OUT_VALID_OUT; endproperty
    a_out_pulse: assert property (p_out_pulse) else $error("long output valid");
    property p_out_hold; !OUT_VALID_OUT |-> $stable(USB_TX_LEFT_OUT); endproperty
    a_out_hold: assert property (p_out_hold) else $error("output moved");
    // Mic feed runs at a third of the tick rate
    property p_mic_cause; MIC_VALID_OUT |-> $past(SAMPLE_EN_IN); endproperty
    a_mic_cause: assert property (p_mic_cause) else $error("mic without tick");
    property p_mic_rate; MIC_VALID_OUT |=> !MIC_VALID_OUT [*8]; endproperty
    a_mic_rate: assert property (p_mic_rate) else $error("mic too often");
    property p_mic_hold; !MIC_VALID_OUT |-> $stable(MIC_TO_PIPE_LEFT_OUT); endproperty
    a_mic_hold: assert property (p_mic_hold) else $error("mic moved");
    // Main scenarios
    c_out: cover property (OUT_VALID_OUT);
    c_mic: cover property (MIC_VALID_OUT);
    c_rb: cover property (RD_IN && ADDR_IN == 8'h2e);
endmodule // route_matrix_props

bind audio_route_gain_matrix route_matrix_props #(.W(W)) route_matrix_props_i (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .SAMPLE_EN_IN(SAMPLE_EN_IN), .OUT_VALID_OUT(OUT_VALID_OUT),
    .USB_TX_LEFT_OUT(USB_TX_LEFT_OUT), .MIC_VALID_OUT(MIC_VALID_OUT),
    .MIC_TO_PIPE_LEFT_OUT(MIC_TO_PIPE_LEFT_OUT)
);

// ---- audio_far_side.sv ----
`timescale 1ns/1ps
module audio_far_side (
    // Clock and control
    input wire clk_in,
    input wire rst_in,
    input wire run_in,
    input wire [3:0] gap_in,
    // Sample tick
    output reg tick_out
);
    reg [3:0] count;
    // Ticks every gap_in cycles, every cycle when gap_in is 0; a long gap models a slow host
    always @(posedge clk_in)
    begin
        if (rst_in || !run_in)
        begin
            count <= 4'h0;
            tick_out <= 1'b0;
        end
        else
        begin
            tick_out <= (count == 4'h0);
            count <= (count + 4'h1 >= gap_in) ? 4'h0 : count + 4'h1;
        end
    end
endmodule // audio_far_side

// ---- audio_route_gain_matrix_tb_top.sv ----
`timescale 1ns/1ps
`include "audio_route_defs.vh"
module audio_route_gain_matrix_tb_top;
    reg clk, rst, wr, rd, run;
    reg [7:0] addr;
    reg [31:0] wdata;
    reg [3:0] gap;
    reg [23:0] ul, ur, sl, sr, pl, pr, ml, mr;
    reg [23:0] psum, pxor;
    wire [23:0] utl, utr, stl, str, erl, err, mtl, mtr;
    wire [31:0] rdata;
    wire tick, ov, mv;
    reg [39:0] rows [0:16];
    reg [47:0] boot;
    integer fails, checks_done, i, j, n;

    audio_route_gain_matrix audio_route_gain_matrix_i (
        .CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .SAMPLE_EN_IN(tick),
        .USB_RX_LEFT_IN(ul), .USB_RX_RIGHT_IN(ur),
        .SERIAL_AUDIO_RX_LEFT_IN(sl), .SERIAL_AUDIO_RX_RIGHT_IN(sr),
        .PIPE_OUT_LEFT_IN(pl), .PIPE_OUT_RIGHT_IN(pr),
        .MIC_RAW_LEFT_IN(ml), .MIC_RAW_RIGHT_IN(mr),
        .USB_TX_LEFT_OUT(utl), .USB_TX_RIGHT_OUT(utr),
        .SERIAL_AUDIO_TX_LEFT_OUT(stl), .SERIAL_AUDIO_TX_RIGHT_OUT(str),
        .ECHO_REFERENCE_LEFT_OUT(erl), .ECHO_REFERENCE_RIGHT_OUT(err),
        .OUT_VALID_OUT(ov), .MIC_TO_PIPE_LEFT_OUT(mtl), .MIC_TO_PIPE_RIGHT_OUT(mtr),
        .MIC_VALID_OUT(mv)
    );
    audio_far_side audio_far_side_i (
        .clk_in(clk), .rst_in(rst), .run_in(run), .gap_in(gap), .tick_out(tick)
    );

    // Free-running 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task check(input [31:0] seen, input [31:0] want);
    begin
        checks_done = checks_done + 1;
        if (seen !== want)
        begin
            fails = fails + 1;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    end
    endtask

    // One idle cycle between accesses keeps each strobe single-driven
    task wr_reg(input [7:0] a, input [31:0] d);
    begin
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    end
    endtask

    task rb(input [7:0] a, input [31:0] want);
    begin
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, want);
    end
    endtask

    // Second pulse is the first one sure to be fed by the new settings
    task wait_pulse(input m);
    begin
        repeat (2)
        begin
            n = 0;
            @(posedge clk);
            #1;
            while ((m ? mv : ov) !== 1'b1 && n < 40)
            begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            if (n >= 40)
                check(32'h1, 32'h0);
        end
    end
    endtask

    task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    // Hang guard
    initial
    begin
        #100000;
        fails = fails + 1;
        tally_and_finish;
    end

    initial
    begin
        fails = 0;
        checks_done = 0;
        {wr, rd, addr, wdata, gap, run, rst} = {2'b0, 8'h0, 32'h0, 4'h3, 1'b0, 1'b1};
        {ul, ur, sl, sr} = {24'h000100, 24'h000040, 24'h000200, 24'h000600};
        {pl, pr, ml, mr} = {24'h000011, 24'h000022, 24'h000003, 24'h000005};
        boot = {8'h08, 8'h07, 8'h09, 8'h05, 8'h06, 8'h05};
        // Rows: source, shift, expected on echo reference left
        rows[0] = {8'h00, 8'h00, 24'h000000};
        rows[1] = {8'h01, 8'h00, 24'h0000a0};
        rows[2] = {8'h02, 8'h00, 24'h000060};
        rows[3] = {8'h03, 8'h00, 24'h000400};
        rows[4] = {8'h04, 8'h00, 24'hfffe00};
        rows[5] = {8'h05, 8'h00, 24'h000011};
        rows[6] = {8'h06, 8'h00, 24'h000022};
        rows[7] = {8'h07, 8'h00, 24'h000100};
        rows[8] = {8'h08, 8'h00, 24'h000040};
        rows[9] = {8'h09, 8'h00, 24'h000200};
        rows[10] = {8'h0a, 8'h00, 24'h000600};
        rows[11] = {8'h0b, 8'h00, 24'h000003};
        rows[12] = {8'h0c, 8'h00, 24'h000005};
        rows[13] = {8'h07, 8'h04, 24'h001000};
        rows[14] = {8'h07, 8'hfc, 24'h000010};
        rows[15] = {8'h07, 8'h14, 24'h7fffff};
        rows[16] = {8'h04, 8'h14, 24'h800000};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        run <= 1'b1;
        for (i = 0; i < 17; i = i + 1)
        begin
            wr_reg(`ROUTE_CMD_ADDR, {16'h0, 8'h04, rows[i][39:32]});
            wr_reg(`SHIFT_CMD_ADDR, {16'h0, 8'h04, rows[i][31:24]});
            wait_pulse(1'b0);
            check(erl, rows[i][23:0]);
            rb(8'h2e, {{24{rows[i][31]}}, rows[i][31:24]});
        end
        // Packed-all on one serial channel drags its partner along
        wr_reg(`ROUTE_CMD_ADDR, 32'h0210);
        rb(8'h27, 32'h10);
        rb(8'h2a, 32'h10);
        // Packed words on serial left: three slots in turn, pulses two ticks apart
        wr_reg(`SHIFT_CMD_ADDR, 32'h0400);
        for (i = 13; i < 17; i = i + 1)
        begin
            wr_reg(`ROUTE_CMD_ADDR, 32'h0200 | i);
            {psum, pxor} = 48'h0;
            for (j = 0; j < 3; j = j + 1)
            begin
                wait_pulse(1'b0);
                psum = psum + stl;
                pxor = pxor ^ stl;
            end
            check(psum, i == 13 ? 32'h33 : i == 14 ? 32'h8 : i == 15 ? 32'hfffe40 : 32'hfffe14);
            check(pxor, i == 13 ? 32'h33 : i == 14 ? 32'h6 : i == 15 ? 32'hfffe40 : 32'hfffe12);
        end
        // Filter 0 enabled: cleared coefficients mute it, then b0 of 1 and 0.5
        rb(8'h52, 32'h0);
        wr_reg(`FILT_BYPASS_ADDR, 32'h0);
        wait_pulse(1'b0);
        check(utl, 32'h0);
        wr_reg(8'h52, 32'h10000000);
        wr_reg(8'h57, 32'h08000000);
        rb(8'h57, 32'h08000000);
        wait_pulse(1'b0);
        check(utl, 32'h8);
        // Bad destination, bad source and an unmapped read change nothing
        wr_reg(`ROUTE_CMD_ADDR, 32'h0601);
        wr_reg(`ROUTE_CMD_ADDR, 32'h0011);
        rb(8'h21, 32'h5);
        rb(8'h00, 32'h0);
        // Mic gain with a slow host: saturating, then wrapping
        gap <= 4'h7;
        wr_reg(`MIC_GAIN_ADDR, 32'h0116);
        wait_pulse(1'b1);
        check(mtl, 24'h7fffff);
        check(mtr, 24'h7fffff);
        wr_reg(`MIC_GAIN_ADDR, 32'h0016);
        wait_pulse(1'b1);
        check(mtl, 24'hc00000);
        check(mtr, 24'h400000);
        // Second reset restores the boot map
        @(posedge clk);
        run <= 1'b0;
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        run <= 1'b1;
        gap <= 4'h3;
        rb(8'h57, 32'h0);
        for (i = 0; i < 6; i = i + 1)
        begin
            rb(8'h20 + 3 * i, i);
            rb(8'h21 + 3 * i, {24'h0, boot[8 * i +: 8]});
            rb(8'h22 + 3 * i, 32'h0);
        end
        wait_pulse(1'b0);
        check(utl, pl);
        check(utr, pr);
        check(stl, pl);
        check(str, sl);
        check(erl, ul);
        check(err, ur);
        tally_and_finish;
    end
endmodule // audio_route_gain_matrix_tb_top
